/* rtl/bws_cfg.svh */
// Purpose: Constants for the write sizing and bus hold block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef BWS_CFG_SVH
`define BWS_CFG_SVH

// Byte lanes on the data bus
`define BWS_LANES        4
// Reset values of the bus-facing outputs
`define BWS_ACK_N_RST    1'b1
`define BWS_LANE_N_RST   4'hf
`define BWS_STROBE_N_RST 1'b1
// Lane masks for the low and high half-word
`define BWS_LOW_HALF     4'h3
`define BWS_HIGH_HALF    4'hc
// Most bus cycles per write sequence for each port width
`define BWS_MAX_CYC_32   3'h1
`define BWS_MAX_CYC_16   3'h2
`define BWS_MAX_CYC_8    3'h4

`endif

/* rtl/bws_pkg.sv */
// Purpose: Types and shared functions of the write sizing block
// Assumes: Nothing beyond the constants header
// Notes:   Constants live in bws_cfg.svh
package bws_pkg;

    // Width of the memory port addressed by a write
    typedef enum logic [1:0] {
        PORT_32,
        PORT_16,
        PORT_8
    } port_width_t;

    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HOLD
    } bus_state_t;

    // Index of the lowest set lane in a mask
    function automatic logic [1:0] lowest_lane(input logic [3:0] mask);
        logic [1:0] idx;
        idx = 2'h3;
        if (mask[2]) begin
            idx = 2'h2;
        end
        if (mask[1]) begin
            idx = 2'h1;
        end
        if (mask[0]) begin
            idx = 2'h0;
        end
        return idx;
    endfunction

endpackage

/* rtl/write_lane_map.sv */
// Purpose: Maps remaining write lanes onto one bus cycle
// Assumes: At least one lane of rem is set when the result is used
// Notes:   Purely combinational; the caller registers the results
`timescale 1ns/10ps
`include "bws_cfg.svh"

module write_lane_map
    import bws_pkg::*;
(
    // Operand
    input  wire logic [31:0] dword_addr,
    input  wire logic [3:0]  rem,
    input  wire logic [31:0] wdata,
    // Cycle presented to the bus
    output logic      [31:0] cyc_addr,
    output logic      [3:0]  cyc_lane_n,
    output logic      [31:0] cyc_data
);

    logic [1:0] low_idx;    // First lane still to be written
    logic [7:0] low_byte;   // Byte found on that lane

    ////////////////////////////////////////////////////////////////////////
    // Address, selects and lane copies
    always_comb begin
        low_idx  = lowest_lane(rem);
        low_byte = wdata[8*low_idx +: 8];
        // Address points at the first byte still owed
        cyc_addr = {dword_addr[31:2], low_idx};
        // Only the lanes still owed are selected
        cyc_lane_n = ~rem;
        // Upper lanes pass unchanged, others may carry anything
        cyc_data[31:16] = wdata[31:16];
        // Lane 3 is copied onto lane 1 when the first owed lane is 2 or 3
        cyc_data[15:8] = low_idx[1] ? wdata[31:24] : wdata[15:8];
        // Lowest owed byte always lands on lane 0
        cyc_data[7:0]  = low_byte;
    end

endmodule

/* rtl/bus_write_sizer.sv */
// Purpose: Turns write operands into sized bus cycles and hands the bus
//          to an outside master on request
// Assumes: One clock equals one bus state; the hold request is sampled
//          once per state at this clock, inputs are synchronous
// Notes:   All bus outputs share one output enable

`timescale 1ns/10ps
`include "bws_cfg.svh"

// Overview of operation
// - 16-bit port: at most two write cycles
// - 8-bit port: at most four write cycles
// - Offset 5 pair: lanes 1,2, lane1 copied down
// - Then address 6, lane 2 only, on lane 0
// - Byte at 7: lane 3 copied to 0,1
// - Unused data lanes may hold anything
// - Give bus up when outside master requests
// - Float bus outputs no later than acknowledge
// - Drop acknowledge once the request is released
// - Sample hold request once per bus state
// - Idle bus: grant at once
// - Mid sequence: grant after sequence and retries
// - No grant between cycles of one sequence
// - Present address, select only written lanes
// - Copy upper lanes down for narrow ports
// - 32-bit port: one cycle
module bus_write_sizer
    import bws_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Write request
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    input  wire logic [2:0]  req_bytes,
    input  wire logic [31:0] req_data,
    input  wire port_width_t req_port,
    output logic             req_ready,
    output logic             req_done,
    // Bus cycle
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_data,
    output logic [3:0]       byte_lane_select_n,
    output logic             cycle_strobe_n,
    output logic             bus_oe,
    input  wire logic        bus_rdy,
    input  wire logic        bus_retry,
    // Bus hand-over
    input  wire logic        hold_req_n,
    output logic             bus_grant_ack_n
);

    ////////////////////////////////////////////////////////////////////////
    // State
    bus_state_t  state_r, state_nxt;        // Controller state
    logic [3:0]  rem_r, rem_nxt;            // Lanes still owed
    logic [31:0] base_r, base_nxt;          // Operand address
    logic [31:0] wdata_r, wdata_nxt;        // Operand data as given
    port_width_t port_r, port_nxt;          // Port width of the sequence
    logic [2:0]  ncyc_r, ncyc_nxt;          // Cycles started in the sequence
    logic [31:0] addr_r, addr_nxt;          // Registered bus address
    logic [31:0] data_r, data_nxt;          // Registered bus data
    logic [3:0]  lane_n_r, lane_n_nxt;      // Registered lane selects
    logic        strobe_n_r, strobe_n_nxt;  // Cycle in progress, low
    logic        oe_r, oe_nxt;              // Bus outputs driven
    logic        ack_n_r, ack_n_nxt;        // Grant acknowledge
    logic        ready_r, ready_nxt;        // Request may be taken
    logic        done_r, done_nxt;          // Sequence finished pulse

    logic [3:0]  req_mask;                  // Lanes of a new request
    logic [3:0]  left;                      // Lanes owed after this cycle
    logic [3:0]  map_rem;                   // Lanes for the next cycle
    logic [31:0] map_base;                  // Address for the next cycle
    logic [31:0] map_wdata;                 // Data for the next cycle
    logic [31:0] map_addr;                  // Mapped address
    logic [31:0] map_data;                  // Mapped data
    logic [3:0]  map_lane_n;                // Mapped selects
    logic        take;                      // New request accepted
    logic        hold_seen;                 // Hold request sampled low

    ////////////////////////////////////////////////////////////////////////
    // Cycle mapping shared by first and later cycles
    write_lane_map u_map (
        .dword_addr (map_base),
        .rem        (map_rem),
        .wdata      (map_wdata),
        .cyc_addr   (map_addr),
        .cyc_lane_n (map_lane_n),
        .cyc_data   (map_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Lanes left after a completed cycle
    always_comb begin
        // Request mask, cut to the addressed double-word
        case (req_bytes)
            3'h1:    req_mask = 4'h1 << req_addr[1:0];
            3'h2:    req_mask = 4'h3 << req_addr[1:0];
            3'h3:    req_mask = 4'h7 << req_addr[1:0];
            3'h4:    req_mask = 4'hf;
            default: req_mask = 4'h0;
        endcase
        case (port_r)
            PORT_32: left = 4'h0;
            // Low half done, high half may remain
            PORT_16: left = (|(rem_r & `BWS_LOW_HALF)) ?
                            (rem_r & `BWS_HIGH_HALF) : 4'h0;
            // Lowest owed byte done
            PORT_8:  left = rem_r & ~(4'h1 << lowest_lane(rem_r));
            default: left = 4'h0;
        endcase
        hold_seen = !hold_req_n;
        take      = (state_r == ST_IDLE) && req_valid && ready_r && !hold_seen
                    && (req_mask != 4'h0);
        map_rem   = take ? req_mask : left;
        map_base  = take ? req_addr : base_r;
        map_wdata = take ? req_data : wdata_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the controller and of the bus outputs
    always_comb begin
        state_nxt    = state_r;
        rem_nxt      = rem_r;
        base_nxt     = base_r;
        wdata_nxt    = wdata_r;
        port_nxt     = port_r;
        ncyc_nxt     = ncyc_r;
        addr_nxt     = addr_r;
        data_nxt     = data_r;
        lane_n_nxt   = lane_n_r;
        strobe_n_nxt = strobe_n_r;
        oe_nxt       = oe_r;
        ack_n_nxt    = ack_n_r;
        ready_nxt    = ready_r;
        done_nxt     = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (hold_seen) begin
                    // Idle bus is handed over at once, floated with the ack
                    state_nxt = ST_HOLD;
                    oe_nxt    = 1'b0;
                    ack_n_nxt = 1'b0;
                    ready_nxt = 1'b0;
                end else if (take) begin
                    // First cycle carries every owed lane
                    state_nxt    = ST_RUN;
                    rem_nxt      = req_mask;
                    base_nxt     = req_addr;
                    wdata_nxt    = req_data;
                    port_nxt     = req_port;
                    ncyc_nxt     = 3'h1;
                    addr_nxt     = map_addr;
                    data_nxt     = map_data;
                    lane_n_nxt   = map_lane_n;
                    strobe_n_nxt = 1'b0;
                    oe_nxt       = 1'b1;
                    ready_nxt    = 1'b0;
                end else begin
                    // Drive an idle bus between sequences
                    oe_nxt    = 1'b1;
                    ready_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                // Hold requests wait here until the sequence ends
                if (bus_rdy && !bus_retry) begin
                    if (left == 4'h0) begin
                        state_nxt    = ST_IDLE;
                        rem_nxt      = 4'h0;
                        lane_n_nxt   = `BWS_LANE_N_RST;
                        strobe_n_nxt = `BWS_STROBE_N_RST;
                        done_nxt     = 1'b1;
                        ready_nxt    = hold_req_n;
                    end else begin
                        // Next cycle of the same sequence
                        rem_nxt    = left;
                        ncyc_nxt   = ncyc_r + 3'h1;
                        addr_nxt   = map_addr;
                        data_nxt   = map_data;
                        lane_n_nxt = map_lane_n;
                    end
                end
            end
            ST_HOLD: begin
                if (!hold_seen) begin
                    // Master let go: take the bus back
                    state_nxt = ST_IDLE;
                    ack_n_nxt = 1'b1;
                    oe_nxt    = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            rem_r      <= 4'h0;
            base_r     <= 32'h0000_0000;
            wdata_r    <= 32'h0000_0000;
            port_r     <= PORT_32;
            ncyc_r     <= 3'h0;
            addr_r     <= 32'h0000_0000;
            data_r     <= 32'h0000_0000;
            lane_n_r   <= `BWS_LANE_N_RST;
            strobe_n_r <= `BWS_STROBE_N_RST;
            oe_r       <= 1'b0;
            ack_n_r    <= `BWS_ACK_N_RST;
            ready_r    <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            rem_r      <= rem_nxt;
            base_r     <= base_nxt;
            wdata_r    <= wdata_nxt;
            port_r     <= port_nxt;
            ncyc_r     <= ncyc_nxt;
            addr_r     <= addr_nxt;
            data_r     <= data_nxt;
            lane_n_r   <= lane_n_nxt;
            strobe_n_r <= strobe_n_nxt;
            oe_r       <= oe_nxt;
            ack_n_r    <= ack_n_nxt;
            ready_r    <= ready_nxt;
            done_r     <= done_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign req_ready          = ready_r;
    assign req_done           = done_r;
    assign bus_addr           = addr_r;
    assign bus_data           = data_r;
    assign byte_lane_select_n = lane_n_r;
    assign cycle_strobe_n     = strobe_n_r;
    assign bus_oe             = oe_r;
    assign bus_grant_ack_n    = ack_n_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_cycles_sixteen: assert property (
        (port_r == PORT_16 && !strobe_n_r) |-> ncyc_r <= `BWS_MAX_CYC_16)
        else $error("16-bit sequence exceeded two cycles");
    chk_cycles_eight: assert property (
        (port_r == PORT_8 && !strobe_n_r) |-> ncyc_r <= `BWS_MAX_CYC_8)
        else $error("8-bit sequence exceeded four cycles");
    chk_cycles_wide: assert property (
        (port_r == PORT_32 && !strobe_n_r && bus_rdy && !bus_retry) |=> strobe_n_r)
        else $error("32-bit write took more than one cycle");
    chk_lane_copy: assert property (
        !strobe_n_r |-> data_r[7:0] == wdata_r[8*lowest_lane(~lane_n_r) +: 8])
        else $error("lane 0 does not carry the lowest written byte");
    chk_high_copy: assert property (
        (!strobe_n_r && lane_n_r == 4'h7) |->
        (data_r[15:8] == wdata_r[31:24] && addr_r[1:0] == 2'h3))
        else $error("single lane 3 byte not copied down");
    chk_lanes_owed: assert property (
        !strobe_n_r |-> ((~lane_n_r & ~rem_r) == 4'h0 && addr_r[31:2] == base_r[31:2]))
        else $error("selected lane not part of the operand");
    chk_float_grant: assert property (
        !ack_n_r |-> !oe_r)
        else $error("bus driven while granted");
    chk_grant_idle: assert property (
        (state_r == ST_IDLE && !hold_req_n) |=> (!ack_n_r && !oe_r))
        else $error("idle bus not granted at once");
    chk_grant_mid: assert property (
        !strobe_n_r |-> ack_n_r)
        else $error("bus granted inside a sequence");
    chk_release_ack: assert property (
        (!ack_n_r && hold_req_n) |=> $rose(ack_n_r))
        else $error("acknowledge not dropped after release");
    chk_grant_after: assert property (
        (!strobe_n_r && bus_rdy && !bus_retry && left == 4'h0 && !hold_req_n)
        |=> ##1 !ack_n_r)
        else $error("grant not given after sequence end");

    cov_two_cycle_half: cover property (
        port_r == PORT_16 && ncyc_r == 3'h2 && !strobe_n_r);
    cov_four_byte_narrow: cover property (
        port_r == PORT_8 && ncyc_r == 3'h4 && !strobe_n_r);
    cov_hold_mid: cover property (
        !strobe_n_r && !hold_req_n ##[1:8] !ack_n_r);
    cov_retry: cover property (!strobe_n_r && bus_rdy && bus_retry);

endmodule

/* tb/bus_far_side.sv */
// Purpose: Far side model: memory that answers cycles, and an outside master
// Assumes: One clock is one bus state
// Notes:   Wait states, retries and hold requests are commanded by the bench
`timescale 1ns/10ps

module bus_far_side (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Bench commands
    input  wire logic [1:0] wait_cycles,
    input  wire logic       retry_en,
    input  wire logic       hold_go,
    // Device bus
    input  wire logic       cycle_strobe_n,
    input  wire logic       bus_oe,
    input  wire logic       bus_grant_ack_n,
    output logic            bus_rdy,
    output logic            bus_retry,
    output logic            hold_req_n
);
    logic [1:0] wait_r;    // Wait states spent on this cycle
    logic       retried_r; // Current cycle already retried once
    logic [1:0] held_r;    // States the bus has been held

    ////////////////////////////////////////////////////////////////////////////////
    // Memory: answer each presented cycle after the wait states
    always @(posedge clock) begin
        if (rst) begin
            bus_rdy <= 1'b0;
            bus_retry <= 1'b0;
            wait_r <= 2'h0;
            retried_r <= 1'b0;
        end else if (bus_rdy) begin
            // Answer lasts one state only
            bus_rdy <= 1'b0;
            bus_retry <= 1'b0;
            wait_r <= 2'h0;
        end else if (!cycle_strobe_n && bus_oe && bus_grant_ack_n) begin
            if (wait_r == wait_cycles) begin
                bus_rdy <= 1'b1;
                bus_retry <= retry_en && !retried_r;
                retried_r <= retry_en && !retried_r;
            end else begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outside master: asks for the bus, uses it only after the grant, returns it
    always @(posedge clock) begin
        if (rst) begin
            hold_req_n <= 1'b1;
            held_r <= 2'h0;
        end else if (hold_req_n && hold_go && bus_grant_ack_n) begin
            // Request; no cycles of ours until the grant shows
            hold_req_n <= 1'b0;
        end else if (!hold_req_n && !bus_grant_ack_n) begin
            // Own the bus a few states, then hand it back
            held_r <= held_r + 2'h1;
            if (held_r == 2'h3) begin
                hold_req_n <= 1'b1;
            end
        end
    end
endmodule

/* tb/bus_write_sizing_and_hold_tb.sv */
// Purpose: Self-checking bench of the write sizing and bus hold block
// Assumes: Expected bus cycles are noted in a queue before each request
// Notes:   A monitor takes one note per completed bus cycle
`timescale 1ns/10ps

module bus_write_sizing_and_hold_tb;
    import bws_pkg::*;

    typedef struct packed {
        logic [31:0] a; // Address
        logic [3:0]  s; // Lane selects, active low
        logic [31:0] d; // Data
        logic [31:0] m; // Lanes that must match
    } note_t;

    logic        clock, rst, req_valid, req_ready, req_done, bus_oe, bus_rdy, bus_retry;
    logic [31:0] req_addr, req_data, bus_addr, bus_data, seed;
    logic [2:0]  req_bytes;
    logic [3:0]  byte_lane_select_n;
    logic        cycle_strobe_n, hold_req_n, bus_grant_ack_n, retry_en, hold_go;
    logic [1:0]  wait_cycles;
    port_width_t req_port;
    note_t       notes[$];  // Expected cycles, oldest first
    note_t       cur;       // Note under comparison
    int          bad_count, total_checks, cycles, k;

    bus_write_sizer u_dut (.clock(clock), .rst(rst), .req_valid(req_valid),
        .req_addr(req_addr), .req_bytes(req_bytes), .req_data(req_data),
        .req_port(req_port), .req_ready(req_ready), .req_done(req_done),
        .bus_addr(bus_addr), .bus_data(bus_data), .byte_lane_select_n(byte_lane_select_n),
        .cycle_strobe_n(cycle_strobe_n), .bus_oe(bus_oe), .bus_rdy(bus_rdy),
        .bus_retry(bus_retry), .hold_req_n(hold_req_n), .bus_grant_ack_n(bus_grant_ack_n));

    bus_far_side u_far (.clock(clock), .rst(rst), .wait_cycles(wait_cycles),
        .retry_en(retry_en), .hold_go(hold_go), .cycle_strobe_n(cycle_strobe_n),
        .bus_oe(bus_oe), .bus_grant_ack_n(bus_grant_ack_n), .bus_rdy(bus_rdy),
        .bus_retry(bus_retry), .hold_req_n(hold_req_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Print counts and the verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Note the bus cycles one write should produce
    task automatic plan_write(input port_width_t p, input logic [31:0] a, input logic [2:0] n,
                              input logic [31:0] d);
        logic [3:0] owed;
        logic [1:0] low;
        note_t      e;
        owed = (4'hf >> (3'h4 - n)) << a[1:0];
        while (owed != 4'h0) begin
            low = owed[0] ? 2'h0 : owed[1] ? 2'h1 : owed[2] ? 2'h2 : 2'h3;
            e.a = {a[31:2], low};
            e.s = ~owed;
            e.d = {d[31:16], (low >= 2'h2) ? d[31:24] : d[15:8], d[8*low +: 8]};
            e.m = {{8{owed[3]}}, {8{owed[2]}}, {8{owed[1] || (low[1] && owed[3])}}, 8'hff};
            notes.push_back(e);
            if (p == PORT_32) begin
                owed = 4'h0;
            end else if (p == PORT_16) begin
                owed = ((owed & 4'h3) != 4'h0) ? (owed & 4'hc) : 4'h0;
            end else begin
                owed[low] = 1'b0;
            end
        end
    endtask

    // Wait for the end of a sequence; every noted cycle must have been seen
    task automatic wait_done();
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (req_done !== 1'b1 && k < 80);
        check(k < 80, 1, "sequence end");
        check(notes.size(), 0, "cycle count");
    endtask

    // One write request, held until taken
    task automatic do_write(input port_width_t p, input logic [31:0] a, input logic [2:0] n);
        seed = lfsr(seed);
        plan_write(p, a, n, seed);
        @(negedge clock);
        {req_valid, req_addr, req_bytes, req_data} = {1'b1, a, n, seed};
        req_port = p;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (!(req_ready === 1'b1 && hold_req_n === 1'b1) && k < 50);
        @(negedge clock);
        req_valid = 1'b0;
        wait_done();
    endtask

    // Count states until the grant takes a given level
    task automatic wait_ack(input logic lvl);
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (bus_grant_ack_n !== lvl && k < 20);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: each completed cycle against the oldest note
    always @(posedge clock) begin
        if (!rst && bus_rdy && !bus_retry && !cycle_strobe_n) begin
            cur = (notes.size() > 0) ? notes.pop_front() : '0;
            check(bus_addr, cur.a, "address");
            check(byte_lane_select_n, cur.s, "lane selects");
            check(bus_data & cur.m, cur.d & cur.m, "data lanes");
            check(bus_grant_ack_n, 1'b1, "grant inside sequence");
        end
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, req_valid, req_addr, req_bytes, req_data} = {1'b1, 1'b0, 32'h0, 3'h1, 32'h0};
        req_port = PORT_32;
        {wait_cycles, retry_en, hold_go, seed} = {2'h0, 1'b0, 1'b0, 32'h01a9eaa7};
        repeat (16) @(negedge clock);
        check(bus_grant_ack_n, 1'b1, "ack at reset");
        check(byte_lane_select_n, 4'hf, "selects at reset");
        rst = 1'b0;
        // Zero byte count is never taken
        {req_valid, req_bytes} = {1'b1, 3'h0};
        repeat (4) @(negedge clock);
        check(cycle_strobe_n, 1'b1, "zero count taken");
        req_valid = 1'b0;
        $display("test reset_refuse done");
        // Every width, offset and count, random wait states
        for (int p = 0; p < 3; p++) begin
            for (int o = 0; o < 4; o++) begin
                for (int n = 1; n <= 4 - o; n++) begin
                    wait_cycles = seed[1:0];
                    do_write(port_width_t'(p), {seed[31:2], 2'(o)}, 3'(n));
                end
            end
        end
        do_write(PORT_16, 32'h00000005, 3'h2);
        do_write(PORT_8, 32'h00000007, 3'h1);
        $display("test sizing done");
        // Every cycle retried once, then taken
        retry_en = 1'b1;
        do_write(PORT_8, 32'h00001000, 3'h4);
        do_write(PORT_16, 32'h00001001, 3'h3);
        retry_en = 1'b0;
        $display("test retry done");
        // Hold in idle: immediate grant, bus floated, then handed back
        @(negedge clock);
        hold_go = 1'b1;
        wait_ack(1'b0);
        check(k <= 3, 1, "idle grant delay");
        check(bus_oe, 1'b0, "float on grant");
        @(negedge clock);
        hold_go = 1'b0;
        wait_ack(1'b1);
        check(k < 20, 1, "grant returned");
        check(bus_oe, 1'b1, "drive after hold");
        $display("test hold_idle done");
        // Hold raised mid sequence with retried cycles: grant only after the last one
        {wait_cycles, retry_en} = {2'h1, 1'b1};
        fork
            do_write(PORT_8, 32'h00002000, 3'h4);
            begin
                repeat (4) @(negedge clock);
                hold_go = 1'b1;
            end
        join
        retry_en = 1'b0;
        wait_ack(1'b0);
        check(k <= 3, 1, "grant after sequence");
        check(bus_oe, 1'b0, "float after sequence");
        @(negedge clock);
        hold_go = 1'b0;
        wait_ack(1'b1);
        check(k < 20, 1, "grant returned");
        $display("test hold_mid done");
        conclude();
    end
endmodule
